/* hw/housekeeping_pkg.sv */
// Constants and types shared by the modem reset, self-test and sleep logic.
// Behaviour
// (RULE_01) Self-test core, both working memories, parameter memory.
// (RULE_02) Memory failure: one pulse per 1.5 s.
// (RULE_03) Core failure: three pulse cycles per group.
// (RULE_04) Parameter memory failure reported to host, not indicator.
// (RULE_05) Sleep after idle timeout without line connection.
// (RULE_06) Sleep powers down everything except clocks.
// (RULE_07) Ring or host character wakes device.
// (RULE_08) Reset input low holds reset, clears memory.
// (RULE_09) Host holds reset low 15 ms minimum.
// (RULE_10) Device ready 25 ms after reset release; the code also waits for the self-tests to end before raising ready.
// (RULE_11) Speaker follows comparator in data and fax.
// (RULE_12) Pattern repeats until reset; quiet when passing.
package housekeeping_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned RESET_HOLD_MIN_MS = 15;
    localparam int unsigned READY_DELAY_MS = 25;
    localparam int unsigned READY_DELAY_CYC = READY_DELAY_MS * CYC_PER_MS;
    localparam int unsigned SLOT_MS = 500;
    localparam int unsigned SLOT_CYC = SLOT_MS * CYC_PER_MS;
    localparam int unsigned GROUP_PERIOD_MS = 1500;
    localparam int unsigned TEST_TIMEOUT_MS = 10;
    localparam int unsigned TEST_TIMEOUT_CYC = TEST_TIMEOUT_MS * CYC_PER_MS;
    localparam int unsigned CNT_W = 32;

    // ------------------------------------------------------------------
    // Indicator patterns, one bit per half-second slot, slot 0 first
    // ------------------------------------------------------------------
    localparam int unsigned SLOT_W = 4;
    localparam logic [8:0] RAM_PATTERN = 9'h001;
    localparam logic [SLOT_W-1:0] RAM_LAST_SLOT = 4'h2;
    localparam logic [8:0] CORE_PATTERN = 9'h015;
    localparam logic [SLOT_W-1:0] CORE_LAST_SLOT = 4'h8;

    // ------------------------------------------------------------------
    // Memory clear and sleep setting
    // ------------------------------------------------------------------
    localparam int unsigned MEM_ADDR_W = 10;
    localparam logic [MEM_ADDR_W-1:0] MEM_LAST_ADDR = 10'h3ff;
    localparam int unsigned TIMEOUT_W = 8;
    localparam logic [TIMEOUT_W-1:0] TIMEOUT_OFF = 8'h00;

    typedef enum logic [1:0] {
        TEST_CORE = 2'b00,
        TEST_IRAM = 2'b01,
        TEST_ERAM = 2'b10,
        TEST_NVRAM = 2'b11
    } test_sel_t;

    typedef enum logic [1:0] {
        MODE_DATA = 2'b00,
        MODE_FAX = 2'b01,
        MODE_VOICE = 2'b10,
        MODE_IDLE = 2'b11
    } line_mode_t;

    typedef enum logic [1:0] {
        ST_CLEAR = 2'b00,
        ST_TEST_START = 2'b01,
        ST_TEST_WAIT = 2'b10,
        ST_RUN = 2'b11
    } top_state_t;

endpackage : housekeeping_pkg

/* hw/self_test_blinker.sv */
// Self-test indicator pattern generator.
`timescale 1ns/1ps
module self_test_blinker
    import housekeeping_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic half_tick_i,
    input wire logic ram_fail_i,
    input wire logic core_fail_i,
    output logic ind_b_o
);

    typedef struct packed {
        logic [SLOT_W-1:0] slot;
        logic ind_b;
    } blink_state_t;

    blink_state_t cur_ff;
    blink_state_t nxt_cur;

    always_comb
    begin
        logic [8:0] pat;
        logic [SLOT_W-1:0] last;
        logic [SLOT_W-1:0] slot;
        pat = core_fail_i ? CORE_PATTERN : RAM_PATTERN;
        last = core_fail_i ? CORE_LAST_SLOT : RAM_LAST_SLOT;
        slot = cur_ff.slot;
        nxt_cur = cur_ff;
        if (!run_i || !(ram_fail_i || core_fail_i))
        begin
            nxt_cur.slot = '0; // RULE_12
            nxt_cur.ind_b = 1'b1; // RULE_12
        end
        else
        begin
            if (half_tick_i)
            begin
                slot = (cur_ff.slot >= last) ? '0 : cur_ff.slot + 4'h1; // RULE_12
            end
            nxt_cur.slot = slot;
            nxt_cur.ind_b = ~pat[slot]; // RULE_02 RULE_03
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cur_ff <= '{slot: '0, ind_b: 1'b1};
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign ind_b_o = cur_ff.ind_b;

endmodule : self_test_blinker

/* hw/sleep_ctrl.sv */
// Idle timer and sleep state of the modem.
`timescale 1ns/1ps
module sleep_ctrl
    import housekeeping_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic enable_i,
    input wire logic sec_tick_i,
    input wire logic [TIMEOUT_W-1:0] sleep_idle_timeout_setting_i,
    input wire logic line_connected_i,
    input wire logic host_char_i,
    input wire logic ring_detect_i,
    output logic asleep_o
);

    typedef struct packed {
        logic [TIMEOUT_W-1:0] idle_sec;
        logic asleep;
    } sleep_state_t;

    sleep_state_t cur_ff;
    sleep_state_t nxt_cur;

    always_comb
    begin
        nxt_cur = cur_ff;
        if (!enable_i)
        begin
            nxt_cur = '0;
        end
        else if (cur_ff.asleep)
        begin
            if (ring_detect_i || host_char_i)
            begin
                nxt_cur.asleep = 1'b0; // RULE_07
                nxt_cur.idle_sec = '0;
            end
        end
        else if (line_connected_i || host_char_i)
        begin
            nxt_cur.idle_sec = '0; // RULE_05
        end
        else if (sleep_idle_timeout_setting_i != TIMEOUT_OFF)
        begin
            // Timeout lowered below the elapsed count still sleeps.
            if (cur_ff.idle_sec >= sleep_idle_timeout_setting_i)
            begin
                nxt_cur.asleep = 1'b1; // RULE_05
            end
            else if (sec_tick_i)
            begin
                nxt_cur.idle_sec = cur_ff.idle_sec + 8'h01;
            end
        end
        else
        begin
            nxt_cur.idle_sec = '0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cur_ff <= '0;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign asleep_o = cur_ff.asleep;

endmodule : sleep_ctrl

/* hw/modem_reset_selftest_sleep.sv */
// Modem housekeeping: reset release, memory clear, self-tests, indicator, sleep, speaker.
`timescale 1ns/1ps
module modem_reset_selftest_sleep
    import housekeeping_pkg::*;
#(
    parameter int unsigned READY_CYC = READY_DELAY_CYC,
    parameter int unsigned HALF_SEC_CYC = SLOT_CYC,
    parameter int unsigned TEST_LIMIT_CYC = TEST_TIMEOUT_CYC
)
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic test_done_i,
    input wire logic test_fail_i,
    input wire logic nvram_present_i,
    input wire logic [TIMEOUT_W-1:0] sleep_idle_timeout_setting_i,
    input wire logic line_connected_i,
    input wire logic host_char_i,
    input wire logic ring_detect_i,
    input wire logic [1:0] line_mode_i,
    input wire logic comparator_i,
    output logic ready_o,
    output logic mem_clear_we_o,
    output logic [MEM_ADDR_W-1:0] mem_clear_addr_o,
    output logic test_start_o,
    output logic [1:0] test_sel_o,
    output logic ram_fail_o,
    output logic core_fail_o,
    output logic nvram_fail_o,
    output logic self_test_ind_b_o,
    output logic sleep_o,
    output logic power_down_o,
    output logic clock_run_o,
    output logic speaker_square_out_o
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        top_state_t st;
        logic [MEM_ADDR_W-1:0] addr;
        logic clr_we;
        test_sel_t sel;
        logic start;
        logic [CNT_W-1:0] test_cnt;
        logic core_fail;
        logic ram_fail;
        logic nvram_fail;
        logic tests_done;
        logic [CNT_W-1:0] rdy_cnt;
        logic delay_done;
        logic ready;
        logic [CNT_W-1:0] div_cnt;
        logic half_tick;
        logic sec_phase;
        logic sec_tick;
        logic spk;
        logic clk_run;
        logic pwr_down;
    } core_state_t;

    localparam core_state_t CORE_RESET = '{
        st: ST_CLEAR,
        addr: '0,
        clr_we: 1'b0,
        sel: TEST_CORE,
        start: 1'b0,
        test_cnt: '0,
        core_fail: 1'b0,
        ram_fail: 1'b0,
        nvram_fail: 1'b0,
        tests_done: 1'b0,
        rdy_cnt: '0,
        delay_done: 1'b0,
        ready: 1'b0,
        div_cnt: '0,
        half_tick: 1'b0,
        sec_phase: 1'b0,
        sec_tick: 1'b0,
        spk: 1'b0,
        clk_run: 1'b1,
        pwr_down: 1'b0
    };

    core_state_t cur_ff;
    core_state_t nxt_cur;
    logic asleep;
    logic spk_mode;
    logic test_timeout;

    assign spk_mode = (line_mode_i == MODE_DATA) || (line_mode_i == MODE_FAX);
    assign test_timeout = (cur_ff.test_cnt == CNT_W'(TEST_LIMIT_CYC - 1));

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.start = 1'b0;
        nxt_cur.half_tick = 1'b0;
        nxt_cur.sec_tick = 1'b0;
        nxt_cur.clk_run = 1'b1; // RULE_06

        // The ready delay counts from release, independent of the tests.
        if (!cur_ff.delay_done)
        begin
            if (cur_ff.rdy_cnt == CNT_W'(READY_CYC - 1))
            begin
                nxt_cur.delay_done = 1'b1; // RULE_10
            end
            else
            begin
                nxt_cur.rdy_cnt = cur_ff.rdy_cnt + 32'h1;
            end
        end
        // Ready waits for both the delay and the end of the tests, so a slow
        // test engine postpones readiness instead of exposing a half-tested part.
        nxt_cur.ready = cur_ff.delay_done && cur_ff.tests_done; // RULE_10

        unique case (cur_ff.st)
            ST_CLEAR:
            begin
                nxt_cur.clr_we = 1'b1; // RULE_08
                if (cur_ff.clr_we)
                begin
                    nxt_cur.addr = cur_ff.addr + 10'h001; // RULE_08
                    if (cur_ff.addr == MEM_LAST_ADDR)
                    begin
                        nxt_cur.clr_we = 1'b0;
                        nxt_cur.addr = '0;
                        nxt_cur.st = ST_TEST_START;
                        nxt_cur.sel = TEST_CORE; // RULE_01
                    end
                end
            end
            ST_TEST_START:
            begin
                if (cur_ff.sel == TEST_NVRAM && !nvram_present_i)
                begin
                    nxt_cur.nvram_fail = 1'b1; // RULE_04
                    nxt_cur.tests_done = 1'b1;
                    nxt_cur.st = ST_RUN;
                end
                else
                begin
                    nxt_cur.start = 1'b1; // RULE_01
                    nxt_cur.test_cnt = '0;
                    nxt_cur.st = ST_TEST_WAIT;
                end
            end
            ST_TEST_WAIT:
            begin
                nxt_cur.test_cnt = cur_ff.test_cnt + 32'h1;
                // A test engine that never answers is counted as a failure.
                if (test_done_i || test_timeout)
                begin
                    unique case (cur_ff.sel)
                        TEST_CORE:
                        begin
                            nxt_cur.core_fail = test_fail_i || !test_done_i; // RULE_03
                        end
                        TEST_IRAM, TEST_ERAM:
                        begin
                            if (test_fail_i || !test_done_i)
                            begin
                                nxt_cur.ram_fail = 1'b1; // RULE_02
                            end
                        end
                        TEST_NVRAM:
                        begin
                            nxt_cur.nvram_fail = test_fail_i || !test_done_i; // RULE_04
                        end
                    endcase
                    if (cur_ff.sel == TEST_NVRAM)
                    begin
                        nxt_cur.tests_done = 1'b1;
                        nxt_cur.st = ST_RUN;
                    end
                    else
                    begin
                        nxt_cur.sel = test_sel_t'(cur_ff.sel + 2'b01); // RULE_01
                        nxt_cur.st = ST_TEST_START;
                    end
                end
            end
            ST_RUN:
            begin
                nxt_cur.st = ST_RUN;
            end
        endcase

        // ------------------------------------------------------------------
        // Half-second divider, started when the tests end so that the first
        // indicator slot has its full length.
        // ------------------------------------------------------------------
        if (cur_ff.st != ST_RUN)
        begin
            nxt_cur.div_cnt = '0;
            nxt_cur.sec_phase = 1'b0;
        end
        else if (cur_ff.div_cnt == CNT_W'(HALF_SEC_CYC - 1))
        begin
            nxt_cur.div_cnt = '0;
            nxt_cur.half_tick = 1'b1; // RULE_02
            nxt_cur.sec_phase = ~cur_ff.sec_phase;
            nxt_cur.sec_tick = cur_ff.sec_phase; // RULE_05
        end
        else
        begin
            nxt_cur.div_cnt = cur_ff.div_cnt + 32'h1;
        end

        // ------------------------------------------------------------------
        // Speaker and power control
        // ------------------------------------------------------------------
        nxt_cur.spk = comparator_i && spk_mode && cur_ff.ready && !asleep; // RULE_11
        nxt_cur.pwr_down = asleep; // RULE_06
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cur_ff <= CORE_RESET; // RULE_08
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    // ------------------------------------------------------------------
    // Indicator and sleep
    // ------------------------------------------------------------------
    self_test_blinker u_blinker (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .run_i(cur_ff.tests_done),
        .half_tick_i(cur_ff.half_tick),
        .ram_fail_i(cur_ff.ram_fail),
        .core_fail_i(cur_ff.core_fail),
        .ind_b_o(self_test_ind_b_o)
    );

    sleep_ctrl u_sleep (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .enable_i(cur_ff.ready),
        .sec_tick_i(cur_ff.sec_tick),
        .sleep_idle_timeout_setting_i(sleep_idle_timeout_setting_i),
        .line_connected_i(line_connected_i),
        .host_char_i(host_char_i),
        .ring_detect_i(ring_detect_i),
        .asleep_o(asleep)
    );

    assign sleep_o = asleep;
    assign ready_o = cur_ff.ready;
    assign mem_clear_we_o = cur_ff.clr_we;
    assign mem_clear_addr_o = cur_ff.addr;
    assign test_start_o = cur_ff.start;
    assign test_sel_o = cur_ff.sel;
    assign ram_fail_o = cur_ff.ram_fail;
    assign core_fail_o = cur_ff.core_fail;
    assign nvram_fail_o = cur_ff.nvram_fail;
    assign power_down_o = cur_ff.pwr_down;
    assign clock_run_o = cur_ff.clk_run;
    assign speaker_square_out_o = cur_ff.spk;

endmodule : modem_reset_selftest_sleep

/* dv/modem_reset_selftest_sleep_asserts.sv */
// Property checker for the modem housekeeping block.
`timescale 1ns/1ps
module modem_reset_selftest_sleep_asserts
    import housekeeping_pkg::*;
#(
    parameter int unsigned READY_CYC = 200,
    parameter int unsigned HALF_SEC_CYC = 20,
    parameter int unsigned TEST_LIMIT_CYC = 100
)
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic test_done_i,
    input wire logic test_fail_i,
    input wire logic nvram_present_i,
    input wire logic [TIMEOUT_W-1:0] sleep_idle_timeout_setting_i,
    input wire logic line_connected_i,
    input wire logic host_char_i,
    input wire logic ring_detect_i,
    input wire logic [1:0] line_mode_i,
    input wire logic comparator_i,
    input wire logic ready_o,
    input wire logic mem_clear_we_o,
    input wire logic [MEM_ADDR_W-1:0] mem_clear_addr_o,
    input wire logic test_start_o,
    input wire logic [1:0] test_sel_o,
    input wire logic ram_fail_o,
    input wire logic core_fail_o,
    input wire logic nvram_fail_o,
    input wire logic self_test_ind_b_o,
    input wire logic sleep_o,
    input wire logic power_down_o,
    input wire logic clock_run_o,
    input wire logic speaker_square_out_o
);
    // ------------------------------------------------------------------
    // Run-length counters of the indicator and time since release
    // ------------------------------------------------------------------
    int unsigned low_run_ff;
    int unsigned hi_run_ff;
    int unsigned rel_cnt_ff;
    logic seen_low_ff;

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            low_run_ff <= 0;
            hi_run_ff <= 0;
            rel_cnt_ff <= 0;
            seen_low_ff <= 1'b0;
        end
        else
        begin
            low_run_ff <= self_test_ind_b_o ? 0 : low_run_ff + 1;
            hi_run_ff <= self_test_ind_b_o ? hi_run_ff + 1 : 0;
            // Saturates so a long soak cannot wrap it back under the limit.
            rel_cnt_ff <= (rel_cnt_ff < READY_CYC) ? rel_cnt_ff + 1 : rel_cnt_ff;
            seen_low_ff <= seen_low_ff | !self_test_ind_b_o;
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_clear_step;
        mem_clear_we_o && (mem_clear_addr_o != MEM_LAST_ADDR);
    endsequence
    sequence s_speak_gate;
        (ready_o && !sleep_o && !line_mode_i[1]) [*2];
    endsequence
    sequence s_gap_end;
        $fell(self_test_ind_b_o) && seen_low_ff;
    endsequence

    property p_clear_walk;
        s_clear_step |=> mem_clear_we_o && (mem_clear_addr_o == $past(mem_clear_addr_o) + 1'b1);
    endproperty
    property p_clear_end;
        mem_clear_we_o && (mem_clear_addr_o == MEM_LAST_ADDR) |=> !mem_clear_we_o;
    endproperty
    property p_start_pulse;
        test_start_o |=> !test_start_o;
    endproperty
    property p_on_len;
        $rose(self_test_ind_b_o) |-> low_run_ff == HALF_SEC_CYC;
    endproperty
    property p_ram_gap;
        s_gap_end and !core_fail_o |-> hi_run_ff == 2 * HALF_SEC_CYC;
    endproperty
    property p_core_gap;
        s_gap_end and core_fail_o |-> hi_run_ff == HALF_SEC_CYC || hi_run_ff == 4 * HALF_SEC_CYC;
    endproperty
    property p_quiet;
        !ram_fail_o && !core_fail_o |-> self_test_ind_b_o;
    endproperty
    property p_ready_delay;
        $rose(ready_o) |-> rel_cnt_ff >= READY_CYC;
    endproperty
    property p_line_hold;
        line_connected_i [*3] |-> !$rose(sleep_o);
    endproperty
    property p_wake;
        sleep_o && (host_char_i || ring_detect_i) |=> !sleep_o;
    endproperty
    property p_power_down;
        $rose(sleep_o) |=> power_down_o && clock_run_o;
    endproperty
    property p_speaker;
        s_speak_gate |-> speaker_square_out_o == $past(comparator_i);
    endproperty
    property p_speaker_mute;
        line_mode_i[1] [*2] |-> !speaker_square_out_o;
    endproperty

    a_clear_walk: assert property (p_clear_walk) else $error("clear walk broken");
    a_clear_end: assert property (p_clear_end) else $error("clear overran");
    a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
    a_on_len: assert property (p_on_len) else $error("on slot length");
    a_ram_gap: assert property (p_ram_gap) else $error("memory gap length");
    a_core_gap: assert property (p_core_gap) else $error("core gap length");
    a_quiet: assert property (p_quiet) else $error("indicator without fail");
    a_ready_delay: assert property (p_ready_delay) else $error("ready too early");
    a_line_hold: assert property (p_line_hold) else $error("slept while connected");
    a_wake: assert property (p_wake) else $error("no wake");
    a_power_down: assert property (p_power_down) else $error("no power down");
    a_speaker: assert property (p_speaker) else $error("speaker mismatch");
    a_speaker_mute: assert property (p_speaker_mute) else $error("speaker not muted");
endmodule : modem_reset_selftest_sleep_asserts

bind modem_reset_selftest_sleep modem_reset_selftest_sleep_asserts #(
    .READY_CYC(READY_CYC), .HALF_SEC_CYC(HALF_SEC_CYC), .TEST_LIMIT_CYC(TEST_LIMIT_CYC)
) chk_u (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .test_done_i(test_done_i),
    .test_fail_i(test_fail_i), .nvram_present_i(nvram_present_i),
    .sleep_idle_timeout_setting_i(sleep_idle_timeout_setting_i),
    .line_connected_i(line_connected_i), .host_char_i(host_char_i),
    .ring_detect_i(ring_detect_i), .line_mode_i(line_mode_i), .comparator_i(comparator_i),
    .ready_o(ready_o), .mem_clear_we_o(mem_clear_we_o), .mem_clear_addr_o(mem_clear_addr_o),
    .test_start_o(test_start_o), .test_sel_o(test_sel_o), .ram_fail_o(ram_fail_o),
    .core_fail_o(core_fail_o), .nvram_fail_o(nvram_fail_o),
    .self_test_ind_b_o(self_test_ind_b_o), .sleep_o(sleep_o), .power_down_o(power_down_o),
    .clock_run_o(clock_run_o), .speaker_square_out_o(speaker_square_out_o)
);

/* dv/test_engine_model.sv */
// Behavioural self-test engine answering start pulses after a chosen latency.
`timescale 1ns/1ps
module test_engine_model
(
    input wire logic ref_clk_i,
    input wire logic start_i,
    input wire logic [1:0] sel_i,
    input wire logic [3:0] fail_mask_i,
    input wire logic [3:0] lat_i,
    output logic done_o,
    output logic fail_o
);
    int wait_cnt = -1;

    initial done_o = 1'b0;
    initial fail_o = 1'b0;

    always @(posedge ref_clk_i)
    begin
        done_o <= 1'b0;
        // The result line toggles outside done so a stale level is never trusted.
        fail_o <= ~fail_o;
        if (start_i)
            wait_cnt <= int'(lat_i);
        else if (wait_cnt == 0)
        begin
            done_o <= 1'b1;
            fail_o <= fail_mask_i[sel_i];
            wait_cnt <= -1;
        end
        else if (wait_cnt > 0)
            wait_cnt <= wait_cnt - 1;
    end
endmodule : test_engine_model

/* dv/modem_reset_selftest_sleep_test.sv */
// Self-checking bench for the modem housekeeping block.
`timescale 1ns/1ps
module modem_reset_selftest_sleep_test;
    import housekeeping_pkg::*;
    localparam int unsigned RDY = 200;
    localparam int unsigned HALF = 20;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic test_done_i, test_fail_i, ready_o, mem_clear_we_o, test_start_o;
    logic ram_fail_o, core_fail_o, nvram_fail_o, self_test_ind_b_o, sleep_o;
    logic power_down_o, clock_run_o, speaker_square_out_o;
    logic nvram_present_i = 1'b1;
    logic [TIMEOUT_W-1:0] sleep_idle_timeout_setting_i = 8'h00;
    logic line_connected_i = 1'b1;
    logic host_char_i = 1'b0;
    logic ring_detect_i = 1'b0;
    logic [1:0] line_mode_i = 2'h0;
    logic comparator_i = 1'b0;
    logic [MEM_ADDR_W-1:0] mem_clear_addr_o;
    logic [1:0] test_sel_o;
    logic [3:0] fail_mask = 4'h0;
    logic [3:0] lat = 4'h0;
    logic [3:0] masks [4] = '{4'h0, 4'h2, 4'h4, 4'hb};
    int clr_cnt = 0;
    int bad_count = 0;
    int total_checks = 0;

    modem_reset_selftest_sleep #(.READY_CYC(RDY), .HALF_SEC_CYC(HALF), .TEST_LIMIT_CYC(100)) dut_u (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .test_done_i(test_done_i),
        .test_fail_i(test_fail_i), .nvram_present_i(nvram_present_i),
        .sleep_idle_timeout_setting_i(sleep_idle_timeout_setting_i),
        .line_connected_i(line_connected_i), .host_char_i(host_char_i),
        .ring_detect_i(ring_detect_i), .line_mode_i(line_mode_i), .comparator_i(comparator_i),
        .ready_o(ready_o), .mem_clear_we_o(mem_clear_we_o), .mem_clear_addr_o(mem_clear_addr_o),
        .test_start_o(test_start_o), .test_sel_o(test_sel_o), .ram_fail_o(ram_fail_o),
        .core_fail_o(core_fail_o), .nvram_fail_o(nvram_fail_o),
        .self_test_ind_b_o(self_test_ind_b_o), .sleep_o(sleep_o), .power_down_o(power_down_o),
        .clock_run_o(clock_run_o), .speaker_square_out_o(speaker_square_out_o));

    test_engine_model eng_u (.ref_clk_i(ref_clk_i), .start_i(test_start_o), .sel_i(test_sel_o),
        .fail_mask_i(fail_mask), .lat_i(lat), .done_o(test_done_i), .fail_o(test_fail_i));

    initial forever #5 ref_clk_i = ~ref_clk_i;

    always @(posedge ref_clk_i)
    begin
        comparator_i <= 1'($urandom_range(1));
        line_mode_i <= 2'($urandom_range(3));
        if (mem_clear_we_o === 1'b1)
            clr_cnt++;
    end

    function automatic logic exp_ind(input int k, input int s);
        if (k == 0)
            return 1'b1;
        if (k == 3)
            return !((s % 9) inside {0, 2, 4});
        return (s % 3) != 0;
    endfunction : exp_ind

    task check(input bit ok, input string msg);
        total_checks++;
        if (!ok)
        begin
            bad_count++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask : check

    task close_out;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    task do_reset;
        rst_b_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
        check(self_test_ind_b_o === 1'b1 && ready_o === 1'b0, "reset state");
        clr_cnt = 0;
        @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
    endtask : do_reset

    task run_case(input int k);
        int n;
        @(posedge ref_clk_i);
        fail_mask <= masks[k];
        nvram_present_i <= (k != 0);
        lat <= 4'($urandom_range(15));
        do_reset();
        n = 0;
        while (ready_o !== 1'b1 && n < 4000)
        begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        check(n >= RDY && ready_o === 1'b1, "ready timing");
        check(clr_cnt == 1024, "memory clear count");
        check({core_fail_o, ram_fail_o, nvram_fail_o} === {k == 3, k != 0, k == 0 || k == 3},
            "fail flags");
        // Sampling mid-slot keeps the check independent of the exact slot edge.
        for (int c = 0; c < 18 * HALF; c++)
        begin
            if (c % HALF == HALF / 2)
                check(self_test_ind_b_o === exp_ind(k, c / HALF), "indicator");
            @(posedge ref_clk_i);
            #1;
        end
    endtask : run_case

    task wait_sleep(input logic exp);
        int n;
        n = 0;
        while (sleep_o !== 1'b1 && n < 300)
        begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        check(sleep_o === exp, "sleep entry");
    endtask : wait_sleep

    task wake(input bit use_ring);
        @(posedge ref_clk_i);
        host_char_i <= !use_ring;
        ring_detect_i <= use_ring;
        @(posedge ref_clk_i);
        host_char_i <= 1'b0;
        ring_detect_i <= 1'b0;
        #1;
        check(sleep_o === 1'b0, "wake");
    endtask : wake

    initial
    begin
        void'($urandom(30889));
        for (int k = 3; k >= 0; k--)
            run_case(k);
        @(posedge ref_clk_i);
        sleep_idle_timeout_setting_i <= 8'($urandom_range(1, 3));
        line_connected_i <= 1'b0;
        wait_sleep(1'b1);
        @(posedge ref_clk_i);
        #1;
        check(power_down_o === 1'b1 && clock_run_o === 1'b1, "power down");
        wake(1'b0);
        wait_sleep(1'b1);
        wake(1'b1);
        @(posedge ref_clk_i);
        line_connected_i <= 1'b1;
        wait_sleep(1'b0);
        @(posedge ref_clk_i);
        line_connected_i <= 1'b0;
        sleep_idle_timeout_setting_i <= TIMEOUT_OFF;
        wait_sleep(1'b0);
        close_out();
    end

    initial
    begin
        #(20000 * 10);
        bad_count++;
        $display("ERROR %0t: watchdog expired", $time);
        close_out();
    end
endmodule : modem_reset_selftest_sleep_test
